/* File: verilog/pcsi_pkg.sv */
// Constants, field layout and operation codes of the program counter unit
package pcsi_pkg;

  // ---------------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------------
  localparam int PCSI_PC_W = 13;
  localparam int PCSI_LIT_W = 11;
  localparam int PCSI_LATCH_W = 5;
  localparam int PCSI_STACK_DEPTH = 8;
  localparam int PCSI_DADDR_W = 9;

  // ---------------------------------------------------------------------
  // Vectors, wrap masks and reset values
  // ---------------------------------------------------------------------
  localparam logic [12:0] PCSI_RESET_VEC = 13'h0000;
  localparam logic [12:0] PCSI_IRQ_VEC = 13'h0004;
  localparam logic [12:0] PCSI_WRAP_256 = 13'h00ff;
  localparam logic [12:0] PCSI_WRAP_512 = 13'h01ff;
  localparam logic [4:0] PCSI_LATCH_RESET = 5'h00;
  localparam logic [7:0] PCSI_PTR_RESET = 8'h00;
  localparam logic PCSI_BANK_RESET = 1'b0;
  localparam logic PCSI_SIZE512_RESET = 1'b1;

  // ---------------------------------------------------------------------
  // File addresses seen by the instruction datapath
  // ---------------------------------------------------------------------
  localparam logic [7:0] PCSI_FA_INDIRECT = 8'h00;
  localparam logic [7:0] PCSI_FA_LOWB = 8'h02;
  localparam logic [7:0] PCSI_FA_STATUS = 8'h03;
  localparam logic [7:0] PCSI_FA_POINTER = 8'h04;
  localparam logic [7:0] PCSI_FA_LATCH = 8'h0a;
  localparam int PCSI_BANK_POS = 7;
  localparam logic [7:0] PCSI_SELF_READ = 8'h00;

  // ---------------------------------------------------------------------
  // APB byte offsets
  // ---------------------------------------------------------------------
  localparam logic [11:0] PCSI_OFS_LOWB = 12'h000;
  localparam logic [11:0] PCSI_OFS_LATCH = 12'h004;
  localparam logic [11:0] PCSI_OFS_POINTER = 12'h008;
  localparam logic [11:0] PCSI_OFS_BANK = 12'h00c;
  localparam logic [11:0] PCSI_OFS_PCVAL = 12'h010;
  localparam logic [11:0] PCSI_OFS_CFG = 12'h014;

  // ---------------------------------------------------------------------
  // Operations issued by the execute stage, one per cycle
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    PCSI_OP_HOLD,
    PCSI_OP_STEP,
    PCSI_OP_GOTO,
    PCSI_OP_CALL,
    PCSI_OP_RET,
    PCSI_OP_RET_LIT,
    PCSI_OP_RET_INT,
    PCSI_OP_IRQ
  } pcsi_op_t;

endpackage

/* File: verilog/pcsi_stack.sv */
// Eight-entry circular return stack with a hidden pointer
`timescale 1ns/1ns
module pcsi_stack
  import pcsi_pkg::*;
#(
  parameter int DEPTH = PCSI_STACK_DEPTH,
  parameter int WIDTH = PCSI_PC_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] top_data
);

  localparam int PW = $clog2(DEPTH);

  // ---------------------------------------------------------------------
  // Pointer
  // ---------------------------------------------------------------------
  logic [PW-1:0] ptr_q;
  logic [PW-1:0] ptr_d;
  logic [PW-1:0] top_idx;
  logic [WIDTH-1:0] entry_q [DEPTH];

  // Pointer simply wraps; no overflow or underflow flag exists
  always_comb begin
    ptr_d = ptr_q;
    if (push) begin
      ptr_d = ptr_q + PW'(1); // see RULE_14
    end else if (pop) begin
      ptr_d = ptr_q - PW'(1); // see RULE_15
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= '0;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  assign top_idx = ptr_q - PW'(1);
  assign top_data = entry_q[top_idx];

  // ---------------------------------------------------------------------
  // Entries
  // ---------------------------------------------------------------------
  // Ninth push lands on the first slot again
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    logic [WIDTH-1:0] entry_d;
    always_comb begin
      entry_d = entry_q[i];
      if (push && (ptr_q == PW'(i))) begin
        entry_d = push_data; // see RULE_14
      end
    end
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        entry_q[i] <= '0;
      end else begin
        entry_q[i] <= entry_d;
      end
    end
  end

  // Eight pushes bring the pointer back where it started
  ptr_wrap_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE_14
    push [*8] |=> (ptr_q == $past(ptr_q, 8)))
    else $error("stack pointer does not wrap after eight pushes");

endmodule

/* File: verilog/pcsi_core.sv */
// Program counter, return stack and indirect addressing unit with APB
`timescale 1ns/1ns
// How it works
// RULE_01 - Program counter is thirteen bits wide, reaching 8K words.
// RULE_02 - Only 256 or 512 words exist; fetch addresses wrap inside them.
// RULE_03 - Reset starts at 0000h; interrupts vector to 0004h.
// RULE_04 - Every reset clears all counter bits.
// RULE_05 - Low eight bits are a read/write register; upper bits come from latch.
// RULE_06 - Writing the low byte loads upper five bits from latch together.
// RULE_07 - Jump and call take the top two counter bits from latch bits 4:3.
// RULE_08 - Jump and call take the low eleven bits from the literal.
// RULE_09 - Software must bump the latch itself when a computed jump rolls over.
// RULE_10 - Stack holds eight 13-bit entries with a hidden pointer.
// RULE_11 - Calls and interrupt branches push the counter.
// RULE_12 - All three return kinds pop into the counter.
// RULE_13 - Pushes and pops leave the high latch alone.
// RULE_14 - Stack is circular; the ninth push overwrites the first.
// RULE_15 - No flag reports stack overflow or underflow.
// RULE_16 - Indirect port has no storage; it reaches the pointed location.
// RULE_17 - Reading the port through itself returns 00h.
// RULE_18 - Writing the port through itself stores nothing.
// RULE_19 - Indirect address is bank bit above the eight-bit pointer.
module pcsi_core
  import pcsi_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pcsi_op_t op_code,
  input wire logic [PCSI_LIT_W-1:0] op_literal,
  input wire logic fa_valid,
  input wire logic fa_write,
  input wire logic [7:0] fa_addr,
  input wire logic [7:0] fa_wdata,
  output logic [7:0] fa_rdata,
  output logic fa_hit,
  output logic dacc_valid,
  output logic dacc_write,
  output logic [PCSI_DADDR_W-1:0] dacc_addr,
  output logic [7:0] dacc_wdata,
  output logic [PCSI_PC_W-1:0] fetch_addr
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic [PCSI_PC_W-1:0] pc_q, pc_d, fetch_q, fetch_d, wrap_mask;
  logic [PCSI_PC_W-1:0] stack_top, push_data;
  logic [PCSI_LATCH_W-1:0] latch_q, latch_d;
  logic [7:0] ptr_q, ptr_d;
  logic bank_q, bank_d, size512_q, size512_d;
  logic push, pop;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [7:0] fa_rdata_q, fa_rdata_d;
  logic fa_hit_q, fa_hit_d;
  logic dacc_valid_q, dacc_valid_d, dacc_write_q, dacc_write_d;
  logic [PCSI_DADDR_W-1:0] dacc_addr_q, dacc_addr_d;
  logic [7:0] dacc_wdata_q, dacc_wdata_d;
  logic apb_acc, apb_we, apb_mapped;
  logic core_we, lowb_we, self_hit;
  logic [7:0] lowb_data;

  // ---------------------------------------------------------------------
  // Shared strobes
  // ---------------------------------------------------------------------
  // Write lands only on the edge where pready is seen high
  assign apb_acc = psel && penable && !pready_q;
  assign apb_we = psel && penable && pready_q && pwrite && apb_mapped;
  assign apb_mapped = (paddr == PCSI_OFS_LOWB) ||
                      (paddr == PCSI_OFS_LATCH) ||
                      (paddr == PCSI_OFS_POINTER) ||
                      (paddr == PCSI_OFS_BANK) ||
                      (paddr == PCSI_OFS_PCVAL) ||
                      (paddr == PCSI_OFS_CFG);
  assign core_we = fa_valid && fa_write;
  assign self_hit = (ptr_q == PCSI_FA_INDIRECT);
  // Core write beats a bus write in the same cycle
  assign lowb_we = (core_we && (fa_addr == PCSI_FA_LOWB)) ||
                   (apb_we && (paddr == PCSI_OFS_LOWB)); // see RULE_05
  assign lowb_data = (core_we && (fa_addr == PCSI_FA_LOWB)) ?
                     fa_wdata : pwdata[7:0];
  assign wrap_mask = size512_q ? PCSI_WRAP_512 : PCSI_WRAP_256;

  // ---------------------------------------------------------------------
  // Program counter and stack control
  // ---------------------------------------------------------------------
  // One operation per cycle; a low-byte write overrides the sequencing
  always_comb begin
    pc_d = pc_q;
    push = 1'b0;
    pop = 1'b0;
    push_data = pc_q + 13'h0001;
    case (op_code)
      PCSI_OP_HOLD: begin
        pc_d = pc_q;
      end
      PCSI_OP_STEP: begin
        pc_d = pc_q + 13'h0001;
      end
      PCSI_OP_GOTO: begin
        pc_d = {latch_q[4:3], op_literal}; // see RULE_07 see RULE_08
      end
      PCSI_OP_CALL: begin
        pc_d = {latch_q[4:3], op_literal}; // see RULE_07 see RULE_08
        push = 1'b1; // see RULE_11
      end
      PCSI_OP_RET, PCSI_OP_RET_LIT, PCSI_OP_RET_INT: begin
        pc_d = stack_top; // see RULE_12
        pop = 1'b1;
      end
      PCSI_OP_IRQ: begin
        push = 1'b1; // see RULE_11
        push_data = pc_q;
        pc_d = PCSI_IRQ_VEC; // see RULE_03
      end
      default: begin
        pc_d = pc_q;
      end
    endcase
    if (lowb_we) begin
      pc_d = {latch_q, lowb_data}; // see RULE_06
    end
    // Upper counter bits stay 13 wide; only the fetch address wraps
    fetch_d = pc_d & wrap_mask; // see RULE_02
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= PCSI_RESET_VEC; // see RULE_04 see RULE_03
      fetch_q <= PCSI_RESET_VEC;
    end else begin
      pc_q <= pc_d; // see RULE_01
      fetch_q <= fetch_d;
    end
  end

  // Hidden-pointer stack; no status output by design
  pcsi_stack #(
    .DEPTH(PCSI_STACK_DEPTH),
    .WIDTH(PCSI_PC_W)
  ) u_stack (
    .clk(clk),
    .rstn(rstn),
    .push(push), // see RULE_10
    .pop(pop),
    .push_data(push_data),
    .top_data(stack_top)
  );

  // ---------------------------------------------------------------------
  // Latch, pointer, bank and size registers
  // ---------------------------------------------------------------------
  // Stack traffic never touches the latch
  always_comb begin
    latch_d = latch_q; // see RULE_13
    ptr_d = ptr_q;
    bank_d = bank_q;
    size512_d = size512_q;
    if (core_we && (fa_addr == PCSI_FA_LATCH)) begin
      latch_d = fa_wdata[PCSI_LATCH_W-1:0];
    end else if (apb_we && (paddr == PCSI_OFS_LATCH)) begin
      latch_d = pwdata[PCSI_LATCH_W-1:0];
    end
    if (core_we && (fa_addr == PCSI_FA_POINTER)) begin
      ptr_d = fa_wdata;
    end else if (apb_we && (paddr == PCSI_OFS_POINTER)) begin
      ptr_d = pwdata[7:0];
    end
    // Bank bit snooped from status writes
    if (core_we && (fa_addr == PCSI_FA_STATUS)) begin
      bank_d = fa_wdata[PCSI_BANK_POS];
    end else if (apb_we && (paddr == PCSI_OFS_BANK)) begin
      bank_d = pwdata[0];
    end
    if (apb_we && (paddr == PCSI_OFS_CFG)) begin
      size512_d = pwdata[0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_q <= PCSI_LATCH_RESET;
      ptr_q <= PCSI_PTR_RESET;
      bank_q <= PCSI_BANK_RESET;
      size512_q <= PCSI_SIZE512_RESET;
    end else begin
      latch_q <= latch_d;
      ptr_q <= ptr_d;
      bank_q <= bank_d;
      size512_q <= size512_d;
    end
  end

  // ---------------------------------------------------------------------
  // File access and indirect resolution
  // ---------------------------------------------------------------------
  // Indirect port has no flop; it redirects through the pointer
  always_comb begin
    fa_rdata_d = 8'h00;
    fa_hit_d = 1'b0;
    dacc_valid_d = 1'b0;
    dacc_write_d = 1'b0;
    dacc_addr_d = '0;
    dacc_wdata_d = fa_wdata;
    if (fa_valid) begin
      if (fa_addr == PCSI_FA_INDIRECT) begin
        if (self_hit) begin
          fa_hit_d = !fa_write;
          fa_rdata_d = PCSI_SELF_READ; // see RULE_17 see RULE_18
        end else begin
          dacc_valid_d = 1'b1; // see RULE_16
          dacc_write_d = fa_write;
          dacc_addr_d = {bank_q, ptr_q}; // see RULE_19
        end
      end else if (fa_addr == PCSI_FA_LOWB) begin
        fa_hit_d = !fa_write;
        fa_rdata_d = pc_q[7:0]; // see RULE_05
      end else if (fa_addr == PCSI_FA_LATCH) begin
        fa_hit_d = !fa_write;
        fa_rdata_d = {3'b000, latch_q};
      end else if (fa_addr == PCSI_FA_POINTER) begin
        fa_hit_d = !fa_write;
        fa_rdata_d = ptr_q;
      end else begin
        // Status and all other files live outside this block
        dacc_valid_d = 1'b1;
        dacc_write_d = fa_write;
        dacc_addr_d = {1'b0, fa_addr};
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fa_rdata_q <= 8'h00;
      fa_hit_q <= 1'b0;
      dacc_valid_q <= 1'b0;
      dacc_write_q <= 1'b0;
      dacc_addr_q <= '0;
      dacc_wdata_q <= 8'h00;
    end else begin
      fa_rdata_q <= fa_rdata_d;
      fa_hit_q <= fa_hit_d;
      dacc_valid_q <= dacc_valid_d;
      dacc_write_q <= dacc_write_d;
      dacc_addr_q <= dacc_addr_d;
      dacc_wdata_q <= dacc_wdata_d;
    end
  end

  // ---------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------
  // One wait state: answer is registered so outputs stay flop-driven
  always_comb begin
    pready_d = apb_acc;
    pslverr_d = apb_acc && !apb_mapped;
    prdata_d = 32'h0000_0000;
    if (apb_acc && !pwrite) begin
      case (paddr)
        PCSI_OFS_LOWB: prdata_d = {24'h00_0000, pc_q[7:0]};
        PCSI_OFS_LATCH: prdata_d = {27'h000_0000, latch_q};
        PCSI_OFS_POINTER: prdata_d = {24'h00_0000, ptr_q};
        PCSI_OFS_BANK: prdata_d = {31'h0000_0000, bank_q};
        PCSI_OFS_PCVAL: prdata_d = {19'h0_0000, pc_q};
        PCSI_OFS_CFG: prdata_d = {31'h0000_0000, size512_q};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fa_rdata = fa_rdata_q;
  assign fa_hit = fa_hit_q;
  assign dacc_valid = dacc_valid_q;
  assign dacc_write = dacc_write_q;
  assign dacc_addr = dacc_addr_q;
  assign dacc_wdata = dacc_wdata_q;
  assign fetch_addr = fetch_q;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  reset_vector_a: assert property (@(posedge clk) // see RULE_04
    $rose(rstn) |-> (pc_q == 13'h0000) && (fetch_q == 13'h0000))
    else $error("counter not zero after reset");

  jump_load_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE_07
    (op_code == PCSI_OP_GOTO) && !lowb_we |=>
      pc_q == {$past(latch_q[4:3]), $past(op_literal)})
    else $error("jump did not load latch bits and literal");

  lowbyte_load_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE_06
    lowb_we |=> pc_q == {$past(latch_q), $past(lowb_data)})
    else $error("low byte write did not load all counter bits");

  irq_vector_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE_03
    (op_code == PCSI_OP_IRQ) && !lowb_we |=> pc_q == 13'h0004)
    else $error("interrupt did not vector to 0004h");

  call_return_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE_12
    ((op_code == PCSI_OP_CALL) && !lowb_we ##1
     (op_code == PCSI_OP_RET) && !lowb_we) |=>
      pc_q == $past(pc_q, 2) + 13'h0001)
    else $error("return did not restore address after call");

  latch_kept_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE_13
    (push || pop) && !(core_we && fa_addr == PCSI_FA_LATCH) &&
      !(apb_we && paddr == PCSI_OFS_LATCH) |=> $stable(latch_q))
    else $error("stack traffic changed the latch");

  self_read_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE_17
    fa_valid && !fa_write && fa_addr == PCSI_FA_INDIRECT && self_hit |=>
      fa_hit_q && (fa_rdata_q == 8'h00) && !dacc_valid_q)
    else $error("self-indirect read not zero");

  self_write_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE_18
    fa_valid && fa_write && fa_addr == PCSI_FA_INDIRECT && self_hit |=>
      !dacc_valid_q && !fa_hit_q)
    else $error("self-indirect write reached memory");

  ind_address_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE_19
    fa_valid && fa_addr == PCSI_FA_INDIRECT && !self_hit |=>
      dacc_valid_q && dacc_addr_q == {$past(bank_q), $past(ptr_q)})
    else $error("indirect address not bank over pointer");

  fetch_wrap_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE_02
    ##1 (fetch_q & ~($past(wrap_mask))) == 13'h0000)
    else $error("fetch address outside implemented memory");

  apb_answer_a: assert property (@(posedge clk) disable iff (!rstn)
    apb_acc |=> pready_q ##1 !pready_q)
    else $error("APB answer not a single-cycle pulse");

  call_seen_c: cover property (@(posedge clk) disable iff (!rstn)
    (op_code == PCSI_OP_CALL) ##1 (op_code == PCSI_OP_RET));
  irq_seen_c: cover property (@(posedge clk) disable iff (!rstn)
    (op_code == PCSI_OP_IRQ) ##1 (op_code == PCSI_OP_RET_INT));
  deep_call_c: cover property (@(posedge clk) disable iff (!rstn)
    (op_code == PCSI_OP_CALL) [*8] ##1 (op_code == PCSI_OP_CALL));
  self_ind_c: cover property (@(posedge clk) disable iff (!rstn)
    fa_valid && fa_addr == PCSI_FA_INDIRECT && self_hit);

endmodule

/* File: bench/pcsi_exec_model.sv */
// Execute stage model driving the operation and file ports of the unit
`timescale 1ns/1ns
module pcsi_exec_model
  import pcsi_pkg::*;
(
  input wire logic clk,
  output pcsi_op_t op_code,
  output logic [PCSI_LIT_W-1:0] op_literal,
  output logic fa_valid,
  output logic fa_write,
  output logic [7:0] fa_addr,
  output logic [7:0] fa_wdata
);
  // Idle values from time zero
  initial begin
    op_code = PCSI_OP_HOLD;
    op_literal = 11'h000;
    fa_valid = 1'b0;
    fa_write = 1'b0;
    fa_addr = 8'hff;
    fa_wdata = 8'hff;
  end

  // One operation per edge; a run of operations ends with a hold
  task automatic issue(input pcsi_op_t c, input logic [10:0] lit);
    op_code <= c;
    op_literal <= lit;
    @(posedge clk);
  endtask

  // One file access, then an idle edge so its answer lands
  task automatic file(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    fa_valid <= 1'b1;
    fa_write <= w;
    fa_addr <= a;
    fa_wdata <= d;
    @(posedge clk);
    fa_valid <= 1'b0;
    fa_addr <= ~a;  // Released address and data lines never keep the old value
    fa_wdata <= ~d;
    @(posedge clk);
  endtask

  // Table jump: no carry reaches the latch, so software sets it itself
  task automatic table_jump(input logic [12:0] base, input logic [7:0] ofs);
    logic [12:0] tgt;
    tgt = base + {5'h00, ofs};
    file(1'b1, PCSI_FA_LATCH, {3'b000, tgt[12:8]});
    file(1'b1, PCSI_FA_LOWB, tgt[7:0]);
  endtask
endmodule

/* File: bench/program_counter_stack_indirect_bench.sv */
// Self-checking bench of the program counter, stack and indirect unit
`timescale 1ns/1ns
module program_counter_stack_indirect_bench
  import pcsi_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, probe = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, fa_valid, fa_write, fa_hit, dacc_valid, dacc_write;
  pcsi_op_t op_code;
  logic [10:0] op_literal;
  logic [7:0] fa_addr, fa_wdata, fa_rdata, dacc_wdata, ptr, wd;
  logic [8:0] dacc_addr;
  logic [12:0] fetch_addr, pc, stk [8];
  logic [4:0] lat;
  logic [63:0] exp_q [$];
  int n_fail = 0, checks_done = 0, sp = 0;
  pcsi_op_t rets [3] = '{PCSI_OP_RET, PCSI_OP_RET_LIT, PCSI_OP_RET_INT};

  always #5 clk = ~clk;

  pcsi_core dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_code(op_code),
    .op_literal(op_literal), .fa_valid(fa_valid), .fa_write(fa_write),
    .fa_addr(fa_addr), .fa_wdata(fa_wdata), .fa_rdata(fa_rdata),
    .fa_hit(fa_hit), .dacc_valid(dacc_valid), .dacc_write(dacc_write),
    .dacc_addr(dacc_addr), .dacc_wdata(dacc_wdata), .fetch_addr(fetch_addr));
  pcsi_exec_model model_u (.clk(clk), .op_code(op_code),
    .op_literal(op_literal), .fa_valid(fa_valid), .fa_write(fa_write),
    .fa_addr(fa_addr), .fa_wdata(fa_wdata));

  // ---------------------------------------------------------------------
  // Result watcher: each result takes the oldest note off the queue
  // ---------------------------------------------------------------------
  always @(posedge clk) begin
    logic [63:0] got;
    logic seen;
    seen = 1'b1;
    got = 64'h0;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && !pwrite)
      got = {8'h01, 23'h0, pslverr, prdata};
    else if (fa_hit === 1'b1) got = {8'h02, 48'h0, fa_rdata};
    else if (dacc_valid === 1'b1)
      got = {8'h03, 38'h0, dacc_wdata, dacc_write, dacc_addr};
    else if (probe) got = {8'h04, 43'h0, fetch_addr};
    else seen = 1'b0;
    if (seen) begin
      checks_done++;
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("wrong value at %0t: got %h expected none", $time, got);
      end else begin
        if (got !== exp_q[0]) begin
          n_fail++;
          $display("wrong value at %0t: got %h expected %h", $time, got,
                   exp_q[0]);
        end
        void'(exp_q.pop_front());
      end
    end
  end

  // ---------------------------------------------------------------------
  // Bus tasks and expectations
  // ---------------------------------------------------------------------
  // Request held until pready is sampled; an idle edge keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait that never gets an answer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic e, input logic [31:0] d);
    exp_q.push_back({8'h01, 23'h0, e, d});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic exp_fa(input logic [7:0] d);
    exp_q.push_back({8'h02, 48'h0, d});
  endtask

  task automatic exp_dacc(input logic w, input logic [8:0] a,
                          input logic [7:0] d);
    exp_q.push_back({8'h03, 38'h0, d, w, a});
  endtask

  task automatic probe_fetch(input logic [12:0] a);
    exp_q.push_back({8'h04, 43'h0, a});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask

  // Jumps and calls take the top two bits from the latch
  task automatic jump(input pcsi_op_t c, input logic [10:0] lit);
    if (c == PCSI_OP_CALL) begin
      stk[sp] = pc + 13'h0001;
      sp = (sp + 1) % 8;
    end
    pc = {lat[4:3], lit};
    model_u.issue(c, lit);
  endtask

  task automatic test_end(input string name);
    $display("test %s done", name);
  endtask

  task automatic print_verdict;
    if (exp_q.size() != 0) n_fail++;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    void'($urandom(15));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(PCSI_OFS_PCVAL, 1'b0, 32'h0000_0000);
    rd(PCSI_OFS_CFG, 1'b0, 32'h0000_0001);
    probe_fetch(PCSI_RESET_VEC);
    rd(12'h018, 1'b1, 32'h0000_0000);
    test_end("reset");
    // Jumps, low byte loads, steps and a table jump across a rollover
    lat = 5'($urandom);
    apb(1'b1, PCSI_OFS_LATCH, {27'h0, lat});
    jump(PCSI_OP_GOTO, 11'($urandom));
    model_u.issue(PCSI_OP_HOLD, 11'h000);
    rd(PCSI_OFS_PCVAL, 1'b0, {19'h0, pc});
    ptr = 8'($urandom);
    pc = {lat, ptr};
    apb(1'b1, PCSI_OFS_LOWB, {24'h0, ptr});
    rd(PCSI_OFS_PCVAL, 1'b0, {19'h0, pc});
    rd(PCSI_OFS_LOWB, 1'b0, {24'h0, ptr});
    model_u.issue(PCSI_OP_STEP, 11'h000);
    model_u.issue(PCSI_OP_STEP, 11'h000);
    model_u.issue(PCSI_OP_HOLD, 11'h000);
    rd(PCSI_OFS_PCVAL, 1'b0, {19'h0, pc + 13'h0002});
    model_u.table_jump(13'h01f0, 8'h30);
    rd(PCSI_OFS_PCVAL, 1'b0, 32'h0000_0220);
    exp_fa(8'h20);
    model_u.file(1'b0, PCSI_FA_LOWB, 8'h00);
    test_end("counter");
    // Nine calls wrap the stack; ten pops show the overwrite
    lat = 5'($urandom);
    apb(1'b1, PCSI_OFS_LATCH, {27'h0, lat});
    for (int i = 0; i < 9; i++) jump(PCSI_OP_CALL, 11'($urandom));
    for (int i = 0; i < 10; i++) begin
      sp = (sp + 7) % 8;
      pc = stk[sp];
      model_u.issue(rets[i % 3], 11'h000);
      model_u.issue(PCSI_OP_HOLD, 11'h000);
      rd(PCSI_OFS_PCVAL, 1'b0, {19'h0, pc});
    end
    rd(PCSI_OFS_LATCH, 1'b0, {27'h0, lat});
    model_u.issue(PCSI_OP_IRQ, 11'h000);
    model_u.issue(PCSI_OP_HOLD, 11'h000);
    rd(PCSI_OFS_PCVAL, 1'b0, {19'h0, PCSI_IRQ_VEC});
    model_u.issue(PCSI_OP_RET_INT, 11'h000);
    model_u.issue(PCSI_OP_HOLD, 11'h000);
    rd(PCSI_OFS_PCVAL, 1'b0, {19'h0, pc});
    test_end("stack");
    // Fetch address wraps in the small memory, counter keeps 13 bits
    lat = 5'h18;
    apb(1'b1, PCSI_OFS_LATCH, {27'h0, lat});
    apb(1'b1, PCSI_OFS_CFG, 32'h0000_0000);
    jump(PCSI_OP_GOTO, 11'h1ab);
    model_u.issue(PCSI_OP_HOLD, 11'h000);
    probe_fetch(13'h00ab);
    apb(1'b1, PCSI_OFS_CFG, 32'h0000_0001);
    jump(PCSI_OP_GOTO, 11'h1ab);
    model_u.issue(PCSI_OP_HOLD, 11'h000);
    probe_fetch(13'h01ab);
    test_end("wrap");
    // Indirect accesses, bank capture and the self-pointing port
    ptr = 8'($urandom) | 8'h01;
    apb(1'b1, PCSI_OFS_POINTER, {24'h0, ptr});
    apb(1'b1, PCSI_OFS_BANK, 32'h0000_0001);
    exp_dacc(1'b0, {1'b1, ptr}, 8'h00);
    model_u.file(1'b0, PCSI_FA_INDIRECT, 8'h00);
    wd = 8'($urandom);
    exp_dacc(1'b1, {1'b1, ptr}, wd);
    model_u.file(1'b1, PCSI_FA_INDIRECT, wd);
    exp_dacc(1'b1, {1'b0, PCSI_FA_STATUS}, 8'h00);
    model_u.file(1'b1, PCSI_FA_STATUS, 8'h00);
    rd(PCSI_OFS_BANK, 1'b0, 32'h0000_0000);
    apb(1'b1, PCSI_OFS_POINTER, 32'h0000_0000);
    exp_fa(PCSI_SELF_READ);
    model_u.file(1'b0, PCSI_FA_INDIRECT, 8'h00);
    model_u.file(1'b1, PCSI_FA_INDIRECT, 8'h5a);
    exp_fa(8'h00);
    model_u.file(1'b0, PCSI_FA_POINTER, 8'h00);
    test_end("indirect");
    // A second reset in mid-run clears a counter that is not zero
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(PCSI_OFS_PCVAL, 1'b0, 32'h0000_0000);
    probe_fetch(PCSI_RESET_VEC);
    test_end("second reset");
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule
